// ### tb/sbtc_ext_clk.sv
// Model of the external count clock source
`default_nettype none
module sbtc_ext_clk (
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 1'b0;
  // ------------------------------------------------------------
  // Bursts
  // ------------------------------------------------------------
  // Stands low between bursts, so stray edges never reach the count
  // Called just after a rising edge: 10 ns keeps changes off that edge
  task automatic burst(input int n, input int half);
    #10;
    repeat (n) begin
      #(half) pin = 1'b1;
      #(half) pin = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/sbtc_top_bench.sv
// Self-checking bench for the sixteen-bit timer counter
`default_nettype none
module sbtc_top_bench
  import sbtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, sys_in;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, osc_on, ovf, ext_pin;
  logic [7:0]  rd;
  int          n_errors, cmp_count, n_ovf, cyc;
  sbtc_ext_clk ext (.pin(ext_pin));
  sbtc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_clock_pin(ext_pin),
    .sysclk_from_timer_osc(sys_in), .timer_osc_on(osc_on),
    .overflow_pulse(ovf));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Internal tick phase is free running, so a small window is allowed
  task automatic chk_rng(input string nm, input int lo, input int hi);
    cmp_count++;
    if ($isunknown(rd) || rd < lo || rd > hi) begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, rd);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {20'h00000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
    chk("hresp", 8'h00, {7'h00, hresp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdb(input logic [11:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_ctrl();
    rdb(SBTC_OFS_CTRL); chk("ctrl rst", SBTC_CTRL_RST, rd);
    rdb(SBTC_OFS_LOW);  chk("low rst", 8'h00, rd);
    wr(SBTC_OFS_CTRL, 8'hFF);
    rdb(SBTC_OFS_CTRL); chk("ctrl ro bit", 8'hBF, rd);
    chk("osc on", 8'h01, {7'h00, osc_on});
    sys_in <= 1'b1;
    repeat (3) @(posedge hclk);
    rdb(SBTC_OFS_CTRL); chk("sys status", 8'hFF, rd);
    sys_in <= 1'b0;
    wr(SBTC_OFS_CTRL, 8'h00);
    repeat (2) @(posedge hclk);
    chk("osc off", 8'h00, {7'h00, osc_on});
    rdb(12'h00C); chk("unmapped", 8'h00, rd);
  endtask
  task automatic t_internal();
    for (int p = 0; p < 4; p++) begin
      wr(SBTC_OFS_LOW, 8'h00);
      wr(SBTC_OFS_CTRL, {2'b00, 2'(p), 1'b0, 1'(p), 2'b01});
      repeat (128) @(posedge hclk);
      wr(SBTC_OFS_CTRL, 8'h00);
      rdb(SBTC_OFS_LOW);
      chk_rng("int count", (32 >> p) - 1, (32 >> p) + 2);
    end
    repeat (40) @(posedge hclk);
    rdb(SBTC_OFS_LOW); chk("stopped", 8'd4, rd);
  endtask
  task automatic t_external();
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(SBTC_OFS_LOW, 8'h00);
        wr(SBTC_OFS_CTRL, {2'b00, 2'(p), 1'b0, 1'(s), 2'b11});
        ext.burst(16, s ? 200 : 60);
        repeat (10) @(posedge hclk);
        wr(SBTC_OFS_CTRL, 8'h00);
        rdb(SBTC_OFS_LOW); chk("ext count", 8'(16 >> p), rd);
      end
    end
  endtask
  task automatic t_overflow();
    wr(SBTC_OFS_LOW, 8'hFF);
    wr(SBTC_OFS_HIGH, 8'hFF);
    n_ovf = 0;
    wr(SBTC_OFS_CTRL, 8'h03);
    ext.burst(1, 100);
    repeat (10) @(posedge hclk);
    chk("ovf pulses", 8'h01, 8'(n_ovf));
    rdb(SBTC_OFS_HIGH); chk("high wrap", 8'h00, rd);
    wr(SBTC_OFS_CTRL, 8'h00);
  endtask
  task automatic t_wide();
    wr(SBTC_OFS_CTRL, 8'h80);
    wr(SBTC_OFS_HIGH, 8'h5A);
    rdb(SBTC_OFS_LOW);
    rdb(SBTC_OFS_HIGH); chk("high held", 8'h00, rd);
    wr(SBTC_OFS_LOW, 8'h3C);
    rdb(SBTC_OFS_LOW);  chk("wide low", 8'h3C, rd);
    rdb(SBTC_OFS_HIGH); chk("wide high", 8'h5A, rd);
    wr(SBTC_OFS_CTRL, 8'h00);
    wr(SBTC_OFS_HIGH, 8'h77);
    rdb(SBTC_OFS_HIGH); chk("byte high", 8'h77, rd);
  endtask
  // ------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    cyc++;
    if (ovf === 1'b1) begin
      n_ovf++;
    end
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    n_errors  = 0;
    cmp_count = 0;
    n_ovf     = 0;
    cyc       = 0;
    hresetn   = 1'b0;
    hsel      = 1'b0;
    hwrite    = 1'b0;
    sys_in    = 1'b0;
    htrans    = 2'b00;
    haddr = '0;
    hwdata = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_ctrl();
    t_internal();
    t_external();
    t_overflow();
    t_wide();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### verilog/sbtc_pkg.sv
// Package of constants and types for the sixteen-bit timer counter
`default_nettype none
package sbtc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SBTC_OFS_LOW  = 12'h000;
  localparam logic [11:0] SBTC_OFS_HIGH = 12'h004;
  localparam logic [11:0] SBTC_OFS_CTRL = 12'h008;
  localparam logic [7:0]  SBTC_CTRL_RST = 8'h00;
  localparam logic [15:0] SBTC_CNT_RST  = 16'h0000;
  localparam logic [7:0]  SBTC_CTRL_WMASK = 8'hBF;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int SBTC_B_RUN  = 0;
  localparam int SBTC_B_SRC  = 1;
  localparam int SBTC_B_SYNN = 2;
  localparam int SBTC_B_OSC  = 3;
  localparam int SBTC_B_PSLO = 4;
  localparam int SBTC_B_PSHI = 5;
  localparam int SBTC_B_SYS  = 6;
  localparam int SBTC_B_WIDE = 7;
  // ----------------------------------------------------------------
  // Timing: internal tick is the clock divided by four
  // ----------------------------------------------------------------
  localparam int SBTC_INT_DIV = 4;
  localparam logic [1:0] SBTC_INT_LAST = 2'(SBTC_INT_DIV - 1);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wide_access_select;
    logic [1:0] prescale_select;
    logic       timer_osc_enable;
    logic       ext_clock_sync_n;
    logic       count_source_select;
    logic       run_enable;
  } sbtc_ctrl_s;
  typedef enum logic [1:0] {
    SBTC_IDLE = 2'b00,
    SBTC_DATA = 2'b01
  } sbtc_phase_e;
endpackage
`default_nettype wire

// ### verilog/sbtc_prescale.sv
// Prescaler turning count pulses into increment pulses
`default_nettype none
module sbtc_prescale
  import sbtc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic [1:0] sel,
  output logic            pulse
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [2:0] last;
  logic       wrap;
  // --------------------------------------------------------------
  // Divide by 1, 2, 4 or 8
  // --------------------------------------------------------------
  assign last = (sel == 2'b11) ? 3'h7 :
                (sel == 2'b10) ? 3'h3 :
                (sel == 2'b01) ? 3'h1 : 3'h0;
  assign wrap = tick && (cnt_ff >= last);
  assign nxt_cnt = clr  ? 3'h0 :
                   wrap ? 3'h0 :
                   tick ? 3'(cnt_ff + 3'h1) : cnt_ff;
  assign pulse = wrap && !clr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  property p_ps_div8;
    @(posedge hclk) disable iff (!hresetn)
    (sel == 2'b11 && tick && !clr && cnt_ff == 3'h7) |-> pulse;
  endproperty
  a_ps_div8: assert property (p_ps_div8)
    else $error("prescale by 8 missed its pulse");
  property p_ps_clr;
    @(posedge hclk) disable iff (!hresetn)
    clr |=> cnt_ff == 3'h0;
  endproperty
  a_ps_clr: assert property (p_ps_clr)
    else $error("prescaler not cleared");
endmodule
`default_nettype wire

// ### verilog/sbtc_top.sv
// AHB-Lite sixteen-bit timer counter with control register
`default_nettype none
module sbtc_top
  import sbtc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_clock_pin,
  input  wire logic        sysclk_from_timer_osc,
  output logic             timer_osc_on,
  output logic             overflow_pulse
);
  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  sbtc_ctrl_s  ctrl_ff;
  logic [15:0] cnt_ff;
  logic [7:0]  high_buf_ff;
  logic [7:0]  rd_buf_ff;
  logic [31:0] hrdata_ff;
  logic        osc_ff;
  logic        ovf_ff;
  logic        sys_ff;
  logic [2:0]  ext_sync_ff;
  logic        ext_lvl_sync_ff;
  logic        ext_edge_q_ff;
  logic [1:0]  div_ff;
  sbtc_phase_e phase_ff;
  logic        dwr_ff;
  logic [11:0] daddr_ff;
  // --------------------------------------------------------------
  // Address phase capture; writes land in the data phase
  // --------------------------------------------------------------
  wire         take = hsel && hready && htrans[1];
  wire         wr_now = (phase_ff == SBTC_DATA) && dwr_ff;
  wire         wr_low = wr_now && (daddr_ff == SBTC_OFS_LOW);
  wire         wr_high = wr_now && (daddr_ff == SBTC_OFS_HIGH);
  wire         wr_ctrl = wr_now && (daddr_ff == SBTC_OFS_CTRL);
  wire [11:0]  aoff = haddr[11:0];
  wire         rd_take = take && !hwrite;
  wire         rd_low = rd_take && (aoff == SBTC_OFS_LOW);
  wire [7:0]   wbyte = hwdata[7:0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= SBTC_IDLE;
      dwr_ff   <= 1'b0;
      daddr_ff <= 12'h000;
    end else begin
      phase_ff <= take ? SBTC_DATA : SBTC_IDLE;
      dwr_ff   <= take && hwrite;
      daddr_ff <= aoff;
    end
  end
  // --------------------------------------------------------------
  // Count source: external pin passes three flops, edge on agreement
  // --------------------------------------------------------------
  // One-cycle glitches never pass the agreement filter
  wire ext_agree    = (ext_sync_ff[2] == ext_sync_ff[1]);
  wire nxt_ext_sync = ext_agree ? ext_sync_ff[2] : ext_lvl_sync_ff;
  wire ext_lvl_sync = ext_lvl_sync_ff;
  wire ext_lvl_raw  = ext_sync_ff[1];
  // Unsynchronised mode taps the second flop; no raw pin clocks logic
  wire ext_lvl = ctrl_ff.ext_clock_sync_n ? ext_lvl_raw
                                          : ext_lvl_sync;
  wire ext_rise = ext_lvl && !ext_edge_q_ff;
  wire int_tick = (div_ff == SBTC_INT_LAST);
  wire src_tick = ctrl_ff.count_source_select ? ext_rise
                                              : int_tick;
  wire run_tick = src_tick && ctrl_ff.run_enable;
  wire cnt_wr = wr_low || wr_high;
  wire ps_pulse;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync_ff   <= 3'b000;
      ext_lvl_sync_ff <= 1'b0;
      ext_edge_q_ff <= 1'b0;
      div_ff        <= 2'b00;
    end else begin
      ext_sync_ff   <= {ext_sync_ff[1:0], ext_clock_pin};
      ext_lvl_sync_ff <= nxt_ext_sync;
      ext_edge_q_ff <= ext_lvl;
      div_ff        <= 2'(div_ff + 2'b01);
    end
  end
  sbtc_prescale u_ps (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (cnt_wr),
    .tick    (run_tick),
    .sel     (ctrl_ff.prescale_select),
    .pulse   (ps_pulse)
  );
  // --------------------------------------------------------------
  // Counter with byte access and wide-mode buffering
  // --------------------------------------------------------------
  wire         wide = ctrl_ff.wide_access_select;
  wire [15:0]  cnt_inc = 16'(cnt_ff + 16'h0001);
  wire         roll = ps_pulse && (cnt_ff == 16'hFFFF);
  wire [7:0]   nxt_high =
    wr_high ? (wide ? cnt_ff[15:8] : wbyte) :
    wr_low  ? (wide ? high_buf_ff : cnt_ff[15:8]) :
    ps_pulse ? cnt_inc[15:8] : cnt_ff[15:8];
  wire [7:0]   nxt_low =
    wr_low  ? wbyte :
    wr_high ? cnt_ff[7:0] :
    ps_pulse ? cnt_inc[7:0] : cnt_ff[7:0];
  wire [15:0]  nxt_cnt = {nxt_high, nxt_low};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff      <= SBTC_CNT_RST;
      high_buf_ff <= 8'h00;
      ovf_ff      <= 1'b0;
    end else begin
      cnt_ff      <= nxt_cnt;
      high_buf_ff <= (wr_high && wide) ? wbyte : high_buf_ff;
      ovf_ff      <= roll && !cnt_wr;
    end
  end
  // --------------------------------------------------------------
  // Control register; bit 6 is read-only status
  // --------------------------------------------------------------
  wire [7:0]   ctrl_w = wbyte & SBTC_CTRL_WMASK;
  wire [7:0]   ctrl_rd = {ctrl_ff.wide_access_select, sys_ff,
                          ctrl_ff[5:0]};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= sbtc_ctrl_s'({SBTC_CTRL_RST[7], SBTC_CTRL_RST[5:0]});
      osc_ff  <= 1'b0;
      sys_ff  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {ctrl_w[7], ctrl_w[5:0]};
      end
      osc_ff <= ctrl_ff.timer_osc_enable;
      sys_ff <= sysclk_from_timer_osc;
    end
  end
  // --------------------------------------------------------------
  // Read data; low read in wide mode latches the high byte
  // --------------------------------------------------------------
  wire [7:0] hi_view = wide ? rd_buf_ff : cnt_ff[15:8];
  wire [31:0] rd_val =
    (aoff == SBTC_OFS_LOW)  ? {24'h0, cnt_ff[7:0]} :
    (aoff == SBTC_OFS_HIGH) ? {24'h0, hi_view} :
    (aoff == SBTC_OFS_CTRL) ? {24'h0, ctrl_rd} : 32'h0000_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_buf_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      if (rd_low && wide) begin
        rd_buf_ff <= cnt_ff[15:8];
      end
      if (rd_take) begin
        hrdata_ff <= rd_val;
      end
    end
  end
  assign hrdata         = hrdata_ff;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign timer_osc_on   = osc_ff;
  assign overflow_pulse = ovf_ff;
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_rollover;
    ps_pulse && cnt_ff == 16'hFFFF && !cnt_wr;
  endsequence
  property p_ovf;
    @(posedge hclk) disable iff (!hresetn)
    s_rollover |=> overflow_pulse && cnt_ff == 16'h0000;
  endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow");
  property p_stop;
    @(posedge hclk) disable iff (!hresetn)
    (!ctrl_ff.run_enable && !cnt_wr) |=> $stable(cnt_ff);
  endproperty
  a_stop: assert property (p_stop) else $error("ran stopped");
  property p_inc;
    @(posedge hclk) disable iff (!hresetn)
    (ps_pulse && !cnt_wr) |=> cnt_ff == 16'($past(cnt_ff) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc) else $error("bad increment");
  property p_wide_hold;
    @(posedge hclk) disable iff (!hresetn)
    (wr_high && wide && !wr_low) |=> cnt_ff[15:8] == $past(cnt_ff[15:8]);
  endproperty
  a_wide_hold: assert property (p_wide_hold)
    else $error("wide high write not held");
  property p_narrow_high;
    @(posedge hclk) disable iff (!hresetn)
    (wr_high && !wide) |=> cnt_ff[15:8] == $past(wbyte);
  endproperty
  a_narrow_high: assert property (p_narrow_high)
    else $error("narrow high write lost");
  property p_low_wr;
    @(posedge hclk) disable iff (!hresetn)
    wr_low |=> cnt_ff[7:0] == $past(wbyte);
  endproperty
  a_low_wr: assert property (p_low_wr)
    else $error("low write lost");
  property p_sys;
    @(posedge hclk) disable iff (!hresetn)
    sysclk_from_timer_osc [*2] |=> ctrl_rd[SBTC_B_SYS];
  endproperty
  a_sys: assert property (p_sys) else $error("status bit wrong");
  property p_osc;
    @(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> ##1 timer_osc_on == $past(ctrl_w[SBTC_B_OSC], 2);
  endproperty
  a_osc: assert property (p_osc) else $error("osc enable wrong");
  property p_int_src;
    @(posedge hclk) disable iff (!hresetn)
    (!ctrl_ff.count_source_select && ctrl_ff.run_enable && !int_tick)
      |-> !ps_pulse;
  endproperty
  a_int_src: assert property (p_int_src)
    else $error("internal tick wrong");
endmodule
`default_nettype wire
